/* File: hdl/addr_map_pkg.sv */
// Address map constants, region codes and carrier structs for the host
// address decoder. Assumes a 22-bit byte address space from the host port.
`default_nettype none
package addr_map_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 22;
  localparam int COLOR_W = 6;

  // ==========================================================
  // Transaction prefixes
  localparam logic [1:0] PFX_READ  = 2'h0;
  localparam logic [1:0] PFX_CMD   = 2'h1;
  localparam logic [1:0] PFX_WRITE = 2'h2;
  localparam logic [1:0] PFX_UNDEF = 2'h3;

  // ==========================================================
  // Region bounds, inclusive
  localparam logic [21:0] GRAM_LO  = 22'h000000;
  localparam logic [21:0] GRAM_HI  = 22'h03ffff;
  localparam logic [21:0] IDROM_LO = 22'h0c0000;
  localparam logic [21:0] IDROM_HI = 22'h0c0003;
  localparam logic [21:0] FONT_LO  = 22'h0bb23c;
  localparam logic [21:0] FONT_HI  = 22'h0ffffb;
  localparam logic [21:0] FPTR_LO  = 22'h0ffffc;
  localparam logic [21:0] FPTR_HI  = 22'h0fffff;
  localparam logic [21:0] DL_LO    = 22'h100000;
  localparam logic [21:0] DL_HI    = 22'h101fff;
  localparam logic [21:0] PAL_LO   = 22'h102000;
  localparam logic [21:0] PAL_HI   = 22'h1023ff;
  localparam logic [21:0] REG_LO   = 22'h102400;
  localparam logic [21:0] REG_HI   = 22'h10257f;
  localparam logic [21:0] CMD_LO   = 22'h108000;
  localparam logic [21:0] CMD_HI   = 22'h108fff;
  localparam logic [21:0] SHOT_LO  = 22'h1c2000;
  localparam logic [21:0] SHOT_HI  = 22'h1c27ff;
  localparam logic [21:0] WAKE_ADDR = 22'h000000;

  // Identity bytes; values arbitrary
  localparam logic [15:0] CHIP_ID_VAL = 16'h5a01;
  localparam logic [15:0] VER_ID_VAL  = 16'h0002;
  // Font table location word; value arbitrary
  localparam logic [31:0] FONT_PTR_VAL = 32'h000bb23c;

  typedef enum logic [3:0] {
    RGN_NONE, RGN_GRAM, RGN_IDROM, RGN_FONT, RGN_FPTR, RGN_DL,
    RGN_PAL, RGN_REG, RGN_CMD, RGN_SHOT
  } region_e;

  typedef struct packed {
    logic              valid;
    logic [1:0]        prefix;
    logic [ADDR_W-1:0] addr;
  } host_req_s;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              cmd;
    region_e           region;
    logic [ADDR_W-1:0] offset;
  } dec_out_s;

  typedef struct packed {
    logic               de;
    logic               vsync;
    logic               hsync;
    logic               panel_en;
    logic               pclk;
    logic [COLOR_W-1:0] r;
    logic [COLOR_W-1:0] g;
    logic [COLOR_W-1:0] b;
  } video_s;

endpackage
`default_nettype wire

/* File: hdl/id_rom.sv */
// Identity and font pointer byte lookup, combinational.
// Assumes byte offsets already reduced to the low two address bits.
`timescale 1ns/10ps
`default_nettype none
module id_rom
  import addr_map_pkg::*;
(
  input  wire logic [1:0] byte_sel,
  input  wire logic       sel_ptr,
  output logic      [7:0] rdata
);

  // ==========================================================
  // Byte select
  always_comb begin
    if (sel_ptr) begin
      rdata = FONT_PTR_VAL[8*byte_sel +: 8];
    end else begin
      case (byte_sel)
        2'h0:    rdata = CHIP_ID_VAL[7:0];
        2'h1:    rdata = CHIP_ID_VAL[15:8];
        2'h2:    rdata = VER_ID_VAL[7:0];
        default: rdata = VER_ID_VAL[15:8];
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: hdl/host_addr_decoder.sv */
// Host transaction address decoder and power-down pin holding.
// Assumes requests arrive as one-cycle valid strobes already deserialised
// from the serial host port, synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module host_addr_decoder
  import addr_map_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire host_req_s  req,
  input  wire logic       power_down_n,
  input  wire logic       osc_in,
  input  wire video_s     video_in,
  input  wire logic [3:0] touch_out_in,
  input  wire logic [3:0] touch_drive_in,
  input  wire logic       backlight_in,
  output dec_out_s        dec_q,
  output logic            dec_valid_q,
  output logic [7:0]      rom_data_q,
  output logic            wake_q,
  output logic            osc_active_q,
  output video_s          video_q,
  output logic [3:0]      touch_o_q,
  output logic [3:0]      touch_oe_n_q,
  output logic            backlight_q
);

  // ==========================================================
  // Region decode
  region_e           rgn;
  logic [ADDR_W-1:0] base;
  logic              is_rd;
  logic              is_wr;
  logic              ro_rgn;
  logic [7:0]        rom_byte;

  function automatic logic in_rng(input logic [21:0] a,
                                  input logic [21:0] lo,
                                  input logic [21:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    rgn  = RGN_NONE;
    base = GRAM_LO;
    // Identity window checked before font: it shadows font space
    if (in_rng(req.addr, IDROM_LO, IDROM_HI)) begin
      rgn  = RGN_IDROM;
      base = IDROM_LO;
    end else if (in_rng(req.addr, GRAM_LO, GRAM_HI)) begin
      rgn = RGN_GRAM;
    end else if (in_rng(req.addr, FONT_LO, FONT_HI)) begin
      rgn  = RGN_FONT;
      base = FONT_LO;
    end else if (in_rng(req.addr, FPTR_LO, FPTR_HI)) begin
      rgn  = RGN_FPTR;
      base = FPTR_LO;
    end else if (in_rng(req.addr, DL_LO, DL_HI)) begin
      rgn  = RGN_DL;
      base = DL_LO;
    end else if (in_rng(req.addr, PAL_LO, PAL_HI)) begin
      rgn  = RGN_PAL;
      base = PAL_LO;
    end else if (in_rng(req.addr, REG_LO, REG_HI)) begin
      rgn  = RGN_REG;
      base = REG_LO;
    end else if (in_rng(req.addr, CMD_LO, CMD_HI)) begin
      rgn  = RGN_CMD;
      base = CMD_LO;
    end else if (in_rng(req.addr, SHOT_LO, SHOT_HI)) begin
      rgn  = RGN_SHOT;
      base = SHOT_LO;
    end
  end

  assign is_rd  = req.valid && (req.prefix == PFX_READ);
  assign is_wr  = req.valid && (req.prefix == PFX_WRITE);
  // ROM areas are read-only; writes to them are dropped
  assign ro_rgn = (rgn == RGN_IDROM) || (rgn == RGN_FONT) ||
                  (rgn == RGN_FPTR);

  id_rom u_id_rom (
    .byte_sel (req.addr[1:0]),
    .sel_ptr  (rgn == RGN_FPTR),
    .rdata    (rom_byte)
  );

  // ==========================================================
  // Decode result registers
  dec_out_s   dec_d;
  logic       dec_valid_d;
  logic [7:0] rom_data_d;
  logic       wake_d;

  always_comb begin
    dec_d       = '0;
    dec_valid_d = 1'b0;
    rom_data_d  = rom_data_q;
    wake_d      = 1'b0;
    if (req.valid && (req.prefix == PFX_CMD)) begin
      dec_d.cmd    = 1'b1;
      dec_d.offset = req.addr;
      dec_valid_d  = 1'b1;
    end else if ((is_rd || is_wr) && (rgn != RGN_NONE) &&
                 !(is_wr && ro_rgn)) begin
      dec_d.rd     = is_rd;
      dec_d.wr     = is_wr;
      dec_d.region = rgn;
      dec_d.offset = req.addr - base;
      dec_valid_d  = 1'b1;
      if (is_rd && ((rgn == RGN_IDROM) || (rgn == RGN_FPTR))) begin
        rom_data_d = rom_byte;
      end
    end
    // Dummy read at zero doubles as the wake request
    wake_d = is_rd && (req.addr == WAKE_ADDR);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_q       <= '0;
      dec_valid_q <= 1'b0;
      rom_data_q  <= 8'h00;
      wake_q      <= 1'b0;
    end else begin
      dec_q       <= dec_d;
      dec_valid_q <= dec_valid_d;
      rom_data_q  <= rom_data_d;
      wake_q      <= wake_d;
    end
  end

  // ==========================================================
  // Pin states across power-down
  video_s     video_d;
  logic [3:0] touch_o_d;
  logic [3:0] touch_oe_n_d;
  logic       backlight_d;
  logic       osc_active_d;

  always_comb begin
    // Powered: osc pin is a live clock input; in power-down it is ignored
    osc_active_d = power_down_n;
    if (!power_down_n) begin
      video_d      = '0;
      // Hold last state so the panel does not flash on entry
      touch_o_d    = touch_o_q;
      touch_oe_n_d = touch_oe_n_q;
      backlight_d  = backlight_q;
    end else begin
      video_d      = video_in;
      touch_o_d    = touch_out_in;
      touch_oe_n_d = ~touch_drive_in;
      backlight_d  = backlight_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      video_q      <= '0;
      touch_o_q    <= 4'h0;
      touch_oe_n_q <= 4'hf;
      backlight_q  <= 1'b0;
      osc_active_q <= 1'b0;
    end else begin
      video_q      <= video_d;
      touch_o_q    <= touch_o_d;
      touch_oe_n_q <= touch_oe_n_d;
      backlight_q  <= backlight_d;
      osc_active_q <= osc_active_d;
    end
  end

  // ==========================================================
  // Checks
  AST_UNDEF_IGNORED: assert property (
    @(posedge ref_clk) disable iff (srst)
    req.valid && req.prefix == PFX_UNDEF |=> !dec_valid_q)
    else $error("undefined prefix was decoded");
  AST_RESERVED_IGNORED: assert property (
    @(posedge ref_clk) disable iff (srst)
    req.valid && req.prefix != PFX_CMD && rgn == RGN_NONE |=> !dec_valid_q)
    else $error("reserved address was decoded");
  AST_CMD_DECODE: assert property (
    @(posedge ref_clk) disable iff (srst)
    req.valid && req.prefix == PFX_CMD |=> dec_q.cmd && !dec_q.rd)
    else $error("command prefix not decoded");
  AST_RD_GRAM: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rd && req.addr <= GRAM_HI |=> dec_q.region == RGN_GRAM && dec_q.rd)
    else $error("graphics read misdecoded");
  AST_ID_SHADOW: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rd && req.addr == IDROM_LO |=> dec_q.region == RGN_IDROM &&
    rom_data_q == CHIP_ID_VAL[7:0])
    else $error("identity byte wrong");
  AST_SHOT_OFFSET: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rd && req.addr == SHOT_HI |=> dec_q.region == RGN_SHOT &&
    dec_q.offset == $past(req.addr) - SHOT_LO)
    else $error("screenshot offset wrong");
  AST_PD_LOW: assert property (
    @(posedge ref_clk) disable iff (srst)
    !power_down_n |=> video_q == '0)
    else $error("video not low in power-down");
  AST_PD_HOLD: assert property (
    @(posedge ref_clk) disable iff (srst)
    !power_down_n |=> $stable(backlight_q) && $stable(touch_oe_n_q))
    else $error("held pin changed in power-down");
  // Back-to-back reads at zero are legal, so each edge is judged alone
  AST_WAKE: assert property (
    @(posedge ref_clk) disable iff (srst)
    is_rd && req.addr == WAKE_ADDR |=> wake_q)
    else $error("wake pulse missing");
  AST_WAKE_ONLY: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(is_rd && req.addr == WAKE_ADDR) |=> !wake_q)
    else $error("wake pulse without a read at zero");

endmodule
`default_nettype wire

/* File: verification/host_model.sv */
// Host controller model that issues single-byte decoder requests.
// Assumes ref_clk from the bench; one request per call, then idle.
`timescale 1ns/10ps
`default_nettype none
module host_model
  import addr_map_pkg::*;
(
  input  wire logic ref_clk,
  output host_req_s req
);
  // ==========================================================
  // Request driver
  initial req = '0;

  // Idle address is inverted so a stale address is never mistaken for live
  task automatic send(input logic [1:0] p, input logic [21:0] a);
    @(posedge ref_clk);
    #1;
    req = '{valid: 1'b1, prefix: p, addr: a};
    @(posedge ref_clk);
    #1;
    req = '{valid: 1'b0, prefix: ~p, addr: ~a};
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the host address decoder.
// Assumes the host model makes requests; other inputs are driven here.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import addr_map_pkg::*;
;
  // ==========================================================
  // Signals
  logic       ref_clk, srst, power_down_n, osc_in, backlight_in;
  logic       dec_valid_q, wake_q, osc_active_q, backlight_q;
  logic [3:0] touch_out_in, touch_drive_in, touch_o_q, touch_oe_n_q;
  logic [7:0] rom_data_q;
  host_req_s  req;
  video_s     video_in, video_q;
  dec_out_s   dec_q;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cycles = 0;

  host_model host (.ref_clk(ref_clk), .req(req));

  host_addr_decoder uut (
    .ref_clk(ref_clk), .srst(srst), .req(req),
    .power_down_n(power_down_n), .osc_in(osc_in), .video_in(video_in),
    .touch_out_in(touch_out_in), .touch_drive_in(touch_drive_in),
    .backlight_in(backlight_in), .dec_q(dec_q), .dec_valid_q(dec_valid_q),
    .rom_data_q(rom_data_q), .wake_q(wake_q), .osc_active_q(osc_active_q),
    .video_q(video_q), .touch_o_q(touch_o_q), .touch_oe_n_q(touch_oe_n_q),
    .backlight_q(backlight_q)
  );

  // ==========================================================
  // Clock and hang guard
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ==========================================================
  // Checking helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic dc(input logic [1:0] p, input logic [21:0] a,
                    input logic [2:0] rwc, input region_e rg,
                    input logic [21:0] off);
    host.send(p, a);
    chk(32'({dec_valid_q, dec_q.rd, dec_q.wr, dec_q.cmd}), 32'({1'b1, rwc}));
    chk(32'(dec_q.region), 32'(rg));
    chk(32'(dec_q.offset), 32'(off));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(32'(touch_oe_n_q), 32'h0000000f);
    chk(32'(video_q), 32'h00000000);
  endtask

  task automatic t_map();
    dc(PFX_READ, 22'h03ffff, 3'b100, RGN_GRAM, 22'h03ffff);
    dc(PFX_READ, 22'h100004, 3'b100, RGN_DL, 22'h000004);
    dc(PFX_READ, 22'h1023ff, 3'b100, RGN_PAL, 22'h0003ff);
    dc(PFX_READ, 22'h10257f, 3'b100, RGN_REG, 22'h00017f);
    dc(PFX_READ, 22'h108000, 3'b100, RGN_CMD, 22'h000000);
    dc(PFX_READ, 22'h0bb23c, 3'b100, RGN_FONT, 22'h000000);
    dc(PFX_READ, 22'h0ffffb, 3'b100, RGN_FONT, 22'h044dbf);
    dc(PFX_READ, 22'h0ffffd, 3'b100, RGN_FPTR, 22'h000001);
    dc(PFX_READ, 22'h1c27ff, 3'b100, RGN_SHOT, 22'h0007ff);
    dc(PFX_WRITE, 22'h102001, 3'b010, RGN_PAL, 22'h000001);
    host.send(PFX_CMD, 22'h2a1234);
    chk(32'({dec_valid_q, dec_q.rd, dec_q.wr, dec_q.cmd}), 32'h9);
    chk(32'(dec_q.offset), 32'h002a1234);
  endtask

  task automatic t_wake();
    dc(PFX_READ, WAKE_ADDR, 3'b100, RGN_GRAM, 22'h000000);
    chk(32'(wake_q), 32'h1);
    host.send(PFX_READ, 22'h000001);
    chk(32'(wake_q), 32'h0);
  endtask

  task automatic t_rom();
    logic [31:0] ids;
    ids = {VER_ID_VAL, CHIP_ID_VAL};
    for (int i = 0; i < 4; i++) begin
      host.send(PFX_READ, IDROM_LO + 22'(i));
      chk(32'(dec_q.region), 32'(RGN_IDROM));
      chk(32'(rom_data_q), 32'(ids[8*i +: 8]));
      host.send(PFX_READ, FPTR_LO + 22'(i));
      chk(32'(rom_data_q), 32'(FONT_PTR_VAL[8*i +: 8]));
    end
  endtask

  task automatic t_refuse();
    logic [7:0]  keep;
    logic [1:0]  pl[4];
    logic [21:0] al[4];
    keep = rom_data_q;
    pl = '{PFX_UNDEF, PFX_READ, PFX_WRITE, PFX_UNDEF};
    al = '{22'h100000, 22'h1c2800, 22'h0c0001, 22'h000000};
    for (int i = 0; i < 4; i++) begin
      host.send(pl[i], al[i]);
      chk(32'({dec_valid_q, wake_q}), 32'h0);
      chk(32'(rom_data_q), 32'(keep));
    end
  endtask

  task automatic t_power();
    video_in = '1;
    touch_out_in = 4'ha;
    touch_drive_in = 4'hf;
    backlight_in = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(video_q), 32'(video_s'('1)));
    chk(32'(osc_active_q), 32'h1);
    power_down_n = 1'b0;
    touch_out_in = 4'h5;
    touch_drive_in = 4'h0;
    backlight_in = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(video_q), 32'h0);
    chk(32'({touch_o_q, touch_oe_n_q, backlight_q}), 32'h141);
    chk(32'(osc_active_q), 32'h0);
    power_down_n = 1'b1;
  endtask

  // Mid-run reset while the video and touch drive inputs are live, then a fresh request
  task automatic t_rerst();
    video_in = '1;
    touch_drive_in = 4'hf;
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    t_reset();
    srst = 1'b0;
    t_wake();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    power_down_n = 1'b1;
    osc_in = 1'b0;
    video_in = '0;
    touch_out_in = 4'h0;
    touch_drive_in = 4'h0;
    backlight_in = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    t_reset();
    srst = 1'b0;
    t_map();
    t_wake();
    t_rom();
    t_refuse();
    t_power();
    t_rerst();
    complete_run();
  end
endmodule
`default_nettype wire
